// >>> core/xcvr_pkg.sv
package xcvr_pkg;
  // Section geometry
  localparam int SEC_W = 9;
  localparam int NUM_SEC = 2;
  localparam int BUS_W = SEC_W * NUM_SEC;
  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] TEST_A_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] TEST_B_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] TEST_OE_ADDR = 8'h0C;
  localparam logic [ADDR_W-1:0] OBS_A_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] OBS_B_ADDR = 8'h14;
  localparam logic [ADDR_W-1:0] STORE_A_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] STORE_B_ADDR = 8'h1C;
  localparam logic [ADDR_W-1:0] PIN_STAT_ADDR = 8'h20;
  // Field positions
  localparam int CTRL_TEST_BIT = 0;
  localparam int TEST_OE_A_BIT = 0;
  localparam int TEST_OE_B_BIT = 1;
  // Reset values
  localparam logic [BUS_W-1:0] TEST_DATA_RST = 18'h00000;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> core/xcvr_section.sv
`timescale 1ns/100ps
module xcvr_section
  import xcvr_pkg::*;
#(
  parameter int W = SEC_W
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [W-1:0] a_in, // Synchronised A pins
  input wire logic [W-1:0] b_in, // Synchronised B pins
  input wire logic oe_n, // Output enable, active low
  input wire logic dir, // High A to B, low B to A
  input wire logic b_src_sel, // B output source select
  input wire logic a_src_sel, // A output source select
  input wire logic a_edge, // Rising edge of A to B capture clock
  input wire logic b_edge, // Rising edge of B to A capture clock
  input wire logic test_mode, // Normal operation inhibited
  input wire logic [W-1:0] test_a, // Forced A value in test mode
  input wire logic [W-1:0] test_b, // Forced B value in test mode
  input wire logic drv_a, // Force A pins in test mode
  input wire logic drv_b, // Force B pins in test mode
  output logic [W-1:0] a_out, // A pin drive value
  output logic [W-1:0] a_oe, // A pin drive enable
  output logic [W-1:0] b_out, // B pin drive value
  output logic [W-1:0] b_oe, // B pin drive enable
  output logic [W-1:0] store_a, // A side storage register
  output logic [W-1:0] store_b // B side storage register
);
  typedef struct packed {
    logic [W-1:0] store_a;
    logic [W-1:0] store_b;
    logic [W-1:0] a_out;
    logic [W-1:0] b_out;
    logic a_en;
    logic b_en;
  } sec_s;

  sec_s r;
  sec_s next_r;

  // Storage capture and pin drive selection
  always_comb begin
    next_r = r;
    if (!test_mode && a_edge) begin
      next_r.store_a = a_in;
    end
    if (!test_mode && b_edge) begin
      next_r.store_b = b_in;
    end
    if (test_mode) begin
      next_r.a_en = drv_a;
      next_r.b_en = drv_b;
      next_r.a_out = test_a;
      next_r.b_out = test_b;
    end else begin
      next_r.a_en = !oe_n && !dir;
      next_r.b_en = !oe_n && dir;
      next_r.b_out = b_src_sel ? r.store_a : a_in;
      next_r.a_out = a_src_sel ? r.store_b : b_in;
    end
  end

  // Storage keeps no reset; only the drive state is cleared
  always_ff @(posedge aclk) begin
    r <= next_r;
    if (!aresetn) begin
      r.a_en <= 1'b0;
      r.b_en <= 1'b0;
      r.a_out <= '0;
      r.b_out <= '0;
    end
  end

  assign a_out = r.a_out;
  assign b_out = r.b_out;
  assign a_oe = {W{r.a_en}};
  assign b_oe = {W{r.b_en}};
  assign store_a = r.store_a;
  assign store_b = r.store_b;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Direction and isolation checks
  a_to_b_drive_a: assert property (!test_mode && !oe_n && dir |=>
    b_oe == {W{1'b1}} && a_oe == '0) else $error("A to B drive wrong");
  b_to_a_drive_a: assert property (!test_mode && !oe_n && !dir |=>
    a_oe == {W{1'b1}} && b_oe == '0) else $error("B to A drive wrong");
  bus_isolation_a: assert property (!test_mode && oe_n |=>
    a_oe == '0 && b_oe == '0) else $error("Buses not isolated");
  // Capture and hold checks
  a_capture_a: assert property (!test_mode && a_edge |=>
    store_a == $past(a_in)) else $error("A data not stored");
  a_hold_a: assert property (!a_edge |=>
    $stable(store_a)) else $error("A storage changed");
  b_capture_a: assert property (!test_mode && b_edge |=>
    store_b == $past(b_in)) else $error("B data not stored");
  // Source select and test force checks
  live_a_path_a: assert property (!test_mode && !b_src_sel |=>
    b_out == $past(a_in)) else $error("Live A path wrong");
  stored_a_path_a: assert property (!test_mode && b_src_sel |=>
    b_out == $past(store_a)) else $error("Stored A path wrong");
  stored_b_path_a: assert property (!test_mode && a_src_sel |=>
    a_out == $past(store_b)) else $error("Stored B path wrong");
  test_force_a: assert property (test_mode ##1 test_mode |->
    a_oe == {W{$past(drv_a)}} && a_out == $past(test_a))
    else $error("Test force wrong");

  live_ab_c: cover property (!test_mode && !oe_n && dir && !b_src_sel);
  stored_ab_c: cover property (a_edge ##[1:8] (!oe_n && dir && b_src_sel));
  stored_ba_c: cover property (b_edge ##[1:8] (!oe_n && !dir && a_src_sel));
endmodule

// >>> core/xcvr_top.sv
`timescale 1ns/100ps
module xcvr_top
  import xcvr_pkg::*;
(
  input wire logic aclk, // System clock, 40 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [DATA_W-1:0] wdata, // Write data
  input wire logic [STRB_W-1:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [DATA_W-1:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic [BUS_W-1:0] a_pin_in, // A bus pin level
  output logic [BUS_W-1:0] a_pin_out, // A bus drive value
  output logic [BUS_W-1:0] a_pin_oe, // A bus drive enable
  input wire logic [BUS_W-1:0] b_pin_in, // B bus pin level
  output logic [BUS_W-1:0] b_pin_out, // B bus drive value
  output logic [BUS_W-1:0] b_pin_oe, // B bus drive enable
  input wire logic [NUM_SEC-1:0] output_enable_n, // Per section
  input wire logic [NUM_SEC-1:0] flow_dir, // Per section
  input wire logic [NUM_SEC-1:0] a_to_b_capture_clock, // Per section
  input wire logic [NUM_SEC-1:0] b_to_a_capture_clock, // Per section
  input wire logic [NUM_SEC-1:0] b_output_source_select, // Per section
  input wire logic [NUM_SEC-1:0] a_output_source_select // Per section
);
  typedef struct packed {
    logic [BUS_W-1:0] a1;
    logic [BUS_W-1:0] a2;
    logic [BUS_W-1:0] b1;
    logic [BUS_W-1:0] b2;
    logic [NUM_SEC-1:0] oe1;
    logic [NUM_SEC-1:0] oe2;
    logic [NUM_SEC-1:0] dir1;
    logic [NUM_SEC-1:0] dir2;
    logic [NUM_SEC-1:0] bsel1;
    logic [NUM_SEC-1:0] bsel2;
    logic [NUM_SEC-1:0] asel1;
    logic [NUM_SEC-1:0] asel2;
    logic [NUM_SEC-1:0] cab1;
    logic [NUM_SEC-1:0] cab2;
    logic [NUM_SEC-1:0] cab3;
    logic [NUM_SEC-1:0] cba1;
    logic [NUM_SEC-1:0] cba2;
    logic [NUM_SEC-1:0] cba3;
    logic test_mode;
    logic [BUS_W-1:0] test_a;
    logic [BUS_W-1:0] test_b;
    logic drv_a;
    logic drv_b;
    logic [BUS_W-1:0] obs_a;
    logic [BUS_W-1:0] obs_b;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s r;
  state_s next_r;
  logic [BUS_W-1:0] store_a;
  logic [BUS_W-1:0] store_b;
  logic [NUM_SEC-1:0] a_edge;
  logic [NUM_SEC-1:0] b_edge;

  // Byte lane merge for partial writes
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Capture clock rising edges from the synchronised levels
  assign a_edge = r.cab2 & ~r.cab3;
  assign b_edge = r.cba2 & ~r.cba3;

  // Next state: pin synchronisers, test cells and bus slave
  always_comb begin
    logic aw_take;
    logic w_take;
    logic do_write;
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd;
    logic [STRB_W-1:0] ws;
    logic [DATA_W-1:0] mv;
    mv = '0;
    aw_take = awvalid && r.awready;
    w_take = wvalid && r.wready;
    wa = aw_take ? awaddr : r.aw_addr;
    wd = w_take ? wdata : r.w_data;
    ws = w_take ? wstrb : r.w_strb;
    do_write = (r.aw_got || aw_take) && (r.w_got || w_take);
    next_r = r;
    // Two flops on every pin before use
    next_r.a1 = a_pin_in;
    next_r.a2 = r.a1;
    next_r.b1 = b_pin_in;
    next_r.b2 = r.b1;
    next_r.oe1 = output_enable_n;
    next_r.oe2 = r.oe1;
    next_r.dir1 = flow_dir;
    next_r.dir2 = r.dir1;
    next_r.bsel1 = b_output_source_select;
    next_r.bsel2 = r.bsel1;
    next_r.asel1 = a_output_source_select;
    next_r.asel2 = r.asel1;
    next_r.cab1 = a_to_b_capture_clock;
    next_r.cab2 = r.cab1;
    next_r.cab3 = r.cab2;
    next_r.cba1 = b_to_a_capture_clock;
    next_r.cba2 = r.cba1;
    next_r.cba3 = r.cba2;
    // Observe cells sample both pins of each bus bit in test mode
    if (r.test_mode) begin
      next_r.obs_a = r.a2;
      next_r.obs_b = r.b2;
    end
    // Write address and data taken in either order
    if (aw_take) begin
      next_r.aw_got = 1'b1;
      next_r.aw_addr = awaddr;
    end
    if (w_take) begin
      next_r.w_got = 1'b1;
      next_r.w_data = wdata;
      next_r.w_strb = wstrb;
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end
    // Register write once both halves are in
    if (do_write) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      if (wa == CTRL_ADDR) begin
        mv = merge(DATA_W'(r.test_mode), wd, ws);
        next_r.test_mode = mv[CTRL_TEST_BIT];
      end else if (wa == TEST_A_ADDR) begin
        mv = merge(DATA_W'(r.test_a), wd, ws);
        next_r.test_a = mv[BUS_W-1:0];
      end else if (wa == TEST_B_ADDR) begin
        mv = merge(DATA_W'(r.test_b), wd, ws);
        next_r.test_b = mv[BUS_W-1:0];
      end else if (wa == TEST_OE_ADDR) begin
        if (ws[0]) begin
          next_r.drv_a = wd[TEST_OE_A_BIT];
          next_r.drv_b = wd[TEST_OE_B_BIT];
        end
      end else if (wa == OBS_A_ADDR || wa == OBS_B_ADDR ||
                   wa == STORE_A_ADDR || wa == STORE_B_ADDR ||
                   wa == PIN_STAT_ADDR) begin
        next_r.bresp = RESP_OKAY;
      end else begin
        next_r.bresp = RESP_SLVERR;
      end
    end
    // Read path answers on the same edge that takes the address
    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
    if (arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = RDATA_RST;
      if (araddr == CTRL_ADDR) begin
        next_r.rdata = DATA_W'(r.test_mode);
      end else if (araddr == TEST_A_ADDR) begin
        next_r.rdata = DATA_W'(r.test_a);
      end else if (araddr == TEST_B_ADDR) begin
        next_r.rdata = DATA_W'(r.test_b);
      end else if (araddr == TEST_OE_ADDR) begin
        next_r.rdata = DATA_W'({r.drv_b, r.drv_a});
      end else if (araddr == OBS_A_ADDR) begin
        next_r.rdata = DATA_W'(r.obs_a);
      end else if (araddr == OBS_B_ADDR) begin
        next_r.rdata = DATA_W'(r.obs_b);
      end else if (araddr == STORE_A_ADDR) begin
        next_r.rdata = DATA_W'(store_a);
      end else if (araddr == STORE_B_ADDR) begin
        next_r.rdata = DATA_W'(store_b);
      end else if (araddr == PIN_STAT_ADDR) begin
        next_r.rdata = DATA_W'({r.asel2, r.bsel2, r.dir2, r.oe2});
      end else begin
        next_r.rresp = RESP_SLVERR;
      end
    end
    // Ready flags follow the state they lead into
    next_r.awready = !next_r.aw_got && !next_r.bvalid;
    next_r.wready = !next_r.w_got && !next_r.bvalid;
    next_r.arready = !next_r.rvalid;
  end

  // State register with synchronous reset of every field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.oe1 <= '1; // Isolated until the enable pins are seen
      r.oe2 <= '1;
      r.test_a <= TEST_DATA_RST;
      r.test_b <= TEST_DATA_RST;
      r.rdata <= RDATA_RST;
      r.bresp <= RESP_OKAY;
      r.rresp <= RESP_OKAY;
    end else begin
      r <= next_r;
    end
  end

  // Two independent sections side by side
  for (genvar s = 0; s < NUM_SEC; s++) begin : g_sec
    xcvr_section #(
      .W(SEC_W)
    ) u_sec (
      .aclk(aclk),
      .aresetn(aresetn),
      .a_in(r.a2[s*SEC_W +: SEC_W]),
      .b_in(r.b2[s*SEC_W +: SEC_W]),
      .oe_n(r.oe2[s]),
      .dir(r.dir2[s]),
      .b_src_sel(r.bsel2[s]),
      .a_src_sel(r.asel2[s]),
      .a_edge(a_edge[s]),
      .b_edge(b_edge[s]),
      .test_mode(r.test_mode),
      .test_a(r.test_a[s*SEC_W +: SEC_W]),
      .test_b(r.test_b[s*SEC_W +: SEC_W]),
      .drv_a(r.drv_a),
      .drv_b(r.drv_b),
      .a_out(a_pin_out[s*SEC_W +: SEC_W]),
      .a_oe(a_pin_oe[s*SEC_W +: SEC_W]),
      .b_out(b_pin_out[s*SEC_W +: SEC_W]),
      .b_oe(b_pin_oe[s*SEC_W +: SEC_W]),
      .store_a(store_a[s*SEC_W +: SEC_W]),
      .store_b(store_b[s*SEC_W +: SEC_W])
    );
  end

  // Bus outputs straight from the state register
  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;

  default clocking tcb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Section independence, test mode and bus handshake checks
  sec_indep_a: assert property ((!r.oe2[0] && r.oe2[1] &&
    !r.test_mode && r.dir2[0]) |=> b_pin_oe[0] == 1'b1 &&
    b_pin_oe[SEC_W] == 1'b0) else $error("Sections not independent");
  test_entry_a: assert property ((r.test_mode && !r.drv_a &&
    !r.drv_b) ##1 r.test_mode |-> a_pin_oe == '0 && b_pin_oe == '0)
    else $error("Normal drive in test mode");
  normal_only_a: assert property (!r.test_mode |=>
    $stable(r.obs_a)) else $error("Observe cell moved");
  obs_sample_a: assert property (r.test_mode |=>
    r.obs_b == $past(r.b2)) else $error("Observe cell missed");
  wr_resp_a: assert property (awvalid && awready && wvalid && wready
    |=> bvalid) else $error("Write response late");
  bvalid_hold_a: assert property (bvalid && !bready |=> bvalid &&
    $stable(bresp)) else $error("Write response dropped");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid &&
    $stable(rdata)) else $error("Read data dropped");

  test_enter_c: cover property (!r.test_mode ##1 r.test_mode);
  both_sec_c: cover property (a_edge[0] && a_edge[1]);
endmodule

// >>> testbench/bus_far_side.sv
`timescale 1ns/100ps
module bus_far_side
  import xcvr_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic [BUS_W-1:0] dut_out, // Device drive value
  input wire logic [BUS_W-1:0] dut_oe, // Device drive enable
  input wire logic [BUS_W-1:0] far_val, // Value the far agent drives
  input wire logic [BUS_W-1:0] far_en, // Far agent drive enable
  output logic [BUS_W-1:0] level // Resolved bus level
);
  logic [BUS_W-1:0] floating = 18'h00000;

  // Undriven lines have no pull: they flip every cycle
  always @(posedge aclk) begin
    floating <= ~level;
  end

  // Bit by bit resolution; two drivers on one line clash to unknown
  always_comb begin
    for (int i = 0; i < BUS_W; i++) begin
      if (dut_oe[i] && far_en[i]) begin
        level[i] = 1'bx;
      end else if (dut_oe[i]) begin
        level[i] = dut_out[i];
      end else if (far_en[i]) begin
        level[i] = far_val[i];
      end else begin
        level[i] = floating[i];
      end
    end
  end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("[ERR] %s expected %h seen %h", nm, exp, got); \
  end end
module tb
  import xcvr_pkg::*;
;
  typedef struct packed {
    logic [1:0] oe_n, dir, bsel, asel, cab, cba;
    logic [17:0] a, b, ea_oe, ea, eb_oe, eb;
  } row_s;
  logic aclk = 1'b0;
  logic aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [DATA_W-1:0] wdata, rdata, rd;
  logic [STRB_W-1:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [BUS_W-1:0] a_pin_in, a_pin_out, a_pin_oe;
  logic [BUS_W-1:0] b_pin_in, b_pin_out, b_pin_oe;
  logic [BUS_W-1:0] a_val, a_en, b_val, b_en;
  logic [NUM_SEC-1:0] oe_n, dir, bsel, asel, cab, cba;
  int n_mismatch = 0;
  int checked = 0;
  row_s rows [7];

  xcvr_top u_xcvr_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .a_pin_in(a_pin_in), .a_pin_out(a_pin_out),
    .a_pin_oe(a_pin_oe), .b_pin_in(b_pin_in), .b_pin_out(b_pin_out),
    .b_pin_oe(b_pin_oe), .output_enable_n(oe_n), .flow_dir(dir),
    .a_to_b_capture_clock(cab), .b_to_a_capture_clock(cba),
    .b_output_source_select(bsel), .a_output_source_select(asel));
  bus_far_side u_bus_far_side_a (.aclk(aclk), .dut_out(a_pin_out),
    .dut_oe(a_pin_oe), .far_val(a_val), .far_en(a_en), .level(a_pin_in));
  bus_far_side u_bus_far_side_b (.aclk(aclk), .dut_out(b_pin_out),
    .dut_oe(b_pin_oe), .far_val(b_val), .far_en(b_en), .level(b_pin_in));

  // 40 MHz system clock
  always #12.5 aclk = ~aclk;

  function automatic logic [BUS_W-1:0] spread(input logic [1:0] v);
    return {{SEC_W{v[1]}}, {SEC_W{v[0]}}};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Write with address and data offered together, then the response
  task automatic axi_write(input logic [7:0] ad, input logic [31:0] d);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (aw_done && w_done && bvalid === 1'b1) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
      if (!aw_done && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1;
      end
      if (!w_done && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1;
      end
    end
  endtask

  // Read one word into rd and rs
  task automatic axi_read(input logic [7:0] ad);
    bit took;
    took = 0;
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (took && rvalid === 1'b1) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
      if (!took && arready === 1'b1) begin
        arvalid <= 1'b0;
        took = 1;
      end
    end
  endtask

  // Rising edge on the capture clocks, then time to settle
  task automatic pulse(input logic [1:0] ab, input logic [1:0] ba);
    @(posedge aclk);
    cab <= ab;
    cba <= ba;
    cyc(2);
    cab <= 2'h0;
    cba <= 2'h0;
    cyc(4);
  endtask

  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    final_report();
  end

  // Main sequence
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    {oe_n, dir, bsel, asel, cab, cba} = 12'hC00;
    {a_val, b_val, a_en, b_en} = {18'h00000, 18'h00000, 36'h0};
    // Controls, capture, far side values, expected enables and values
    rows = '{
      '{2'h0, 2'h3, 2'h0, 2'h0, 2'h3, 2'h0, 18'h1A5A5, 18'h00000,
        18'h00000, 18'h00000, 18'h3FFFF, 18'h1A5A5},
      '{2'h0, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 18'h05A5A, 18'h00000,
        18'h00000, 18'h00000, 18'h3FFFF, 18'h1A5A5},
      '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 18'h00000, 18'h2C3C3,
        18'h3FFFF, 18'h2C3C3, 18'h00000, 18'h00000},
      '{2'h0, 2'h0, 2'h0, 2'h3, 2'h0, 2'h0, 18'h00000, 18'h13C3C,
        18'h3FFFF, 18'h2C3C3, 18'h00000, 18'h00000},
      '{2'h3, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3, 18'h00FF0, 18'h3F00F,
        18'h00000, 18'h00000, 18'h00000, 18'h00000},
      '{2'h0, 2'h1, 2'h3, 2'h3, 2'h0, 2'h0, 18'h15555, 18'h2AAAA,
        18'h3FE00, 18'h3F000, 18'h001FF, 18'h001F0},
      '{2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 18'h1FFFF, 18'h00000,
        18'h00000, 18'h00000, 18'h001FF, 18'h001FF}};
    cyc(16);
    aresetn <= 1'b1;
    cyc(4);
    foreach (rows[i]) begin
      @(posedge aclk);
      {oe_n, dir, bsel, asel} <= {rows[i].oe_n, rows[i].dir,
                                  rows[i].bsel, rows[i].asel};
      a_val <= rows[i].a;
      b_val <= rows[i].b;
      // Far agents let go until the device has turned round
      a_en <= '0;
      b_en <= '0;
      cyc(4);
      a_en <= spread(rows[i].dir | rows[i].oe_n);
      b_en <= spread(~rows[i].dir | rows[i].oe_n);
      pulse(rows[i].cab, rows[i].cba);
      `CHK("a_pin_oe", rows[i].ea_oe, a_pin_oe)
      `CHK("b_pin_oe", rows[i].eb_oe, b_pin_oe)
      `CHK("a_pin_out", rows[i].ea, a_pin_out & rows[i].ea_oe)
      `CHK("b_pin_out", rows[i].eb, b_pin_out & rows[i].eb_oe)
      $display("test row %0d done", i);
    end
    // Test mode forces B and ignores capture edges
    @(posedge aclk);
    {oe_n, dir, bsel, asel} <= 8'h30;
    a_val <= 18'h0F0F0;
    a_en <= 18'h3FFFF;
    b_en <= 18'h00000;
    axi_write(TEST_A_ADDR, 32'h0002AAAA);
    axi_write(TEST_B_ADDR, 32'h00015555);
    // Enter test mode with no force, then force B
    axi_write(CTRL_ADDR, 32'h00000001);
    axi_write(TEST_OE_ADDR, 32'h00000002);
    cyc(4);
    `CHK("b_pin_oe", 18'h3FFFF, b_pin_oe)
    `CHK("b_pin_out", 18'h15555, b_pin_out)
    `CHK("a_pin_oe", 18'h00000, a_pin_oe)
    a_val <= 18'h3C3C3;
    cyc(4);
    pulse(2'h3, 2'h0);
    axi_read(STORE_A_ADDR);
    `CHK("store_a", 32'h00000FF0, rd)
    axi_read(OBS_A_ADDR);
    `CHK("obs_a", 32'h0003C3C3, rd)
    axi_read(OBS_B_ADDR);
    `CHK("obs_b", 32'h00015555, rd)
    $display("test test_mode done");
    // Back to normal; register traffic must not disturb the pins
    axi_write(CTRL_ADDR, 32'h00000000);
    cyc(4);
    `CHK("b_pin_out", 18'h3C3C3, b_pin_out)
    axi_write(TEST_OE_ADDR, 32'h00000003);
    `CHK("bresp", RESP_OKAY, rs)
    cyc(4);
    `CHK("a_pin_oe", 18'h00000, a_pin_oe)
    `CHK("b_pin_out", 18'h3C3C3, b_pin_out)
    pulse(2'h3, 2'h0);
    axi_read(STORE_A_ADDR);
    `CHK("store_a", 32'h0003C3C3, rd)
    axi_write(STORE_A_ADDR, 32'h00000000);
    `CHK("bresp ro", RESP_OKAY, rs)
    axi_read(8'h24);
    `CHK("rresp", RESP_SLVERR, rs)
    `CHK("rdata", RDATA_RST, rd)
    $display("test normal_access done");
    // Second reset leaves the storage registers alone
    @(posedge aclk);
    aresetn <= 1'b0;
    cyc(3);
    aresetn <= 1'b1;
    cyc(2);
    axi_read(STORE_A_ADDR);
    `CHK("store_a", 32'h0003C3C3, rd)
    axi_read(CTRL_ADDR);
    `CHK("ctrl", 32'h00000000, rd)
    $display("test mid_reset done");
    final_report();
  end
endmodule
